/* src/ircdm_pkg.sv */
// ircdm_pkg: register map, field positions and clock source codes of the
// infrared carrier/data modulator.
// assumes a 16-bit register port with word indices as addresses.
package ircdm_pkg;
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 16;
    localparam logic [3:0]  ADDR_CLK_SEL    = 4'h0;
    localparam logic [3:0]  ADDR_CNT_CTL    = 4'h1;
    localparam logic [3:0]  ADDR_CNT_VAL    = 4'h2;
    localparam logic [3:0]  ADDR_ACT_LEN    = 4'h3;
    localparam logic [3:0]  ADDR_CYC_LEN    = 4'h4;
    localparam logic [3:0]  ADDR_STAT_FLAG  = 4'h5;
    localparam logic [3:0]  ADDR_INT_EN     = 4'h6;
    localparam logic [3:0]  ADDR_CARR_WAVE  = 4'h7;
    localparam logic [3:0]  ADDR_CARR_CTL   = 4'h8;
    // clock_select fields
    localparam int          CS_DEBUG_BIT    = 8;
    localparam int          CS_DIV_LSB      = 4;
    localparam int          CS_SRC_LSB      = 0;
    // counter_control fields
    localparam int          CC_PRESET_BIT   = 9;
    localparam int          CC_RUN_BIT      = 8;
    localparam int          CC_INV_BIT      = 4;
    localparam int          CC_BUF_BIT      = 3;
    localparam int          CC_ONESHOT_BIT  = 2;
    localparam int          CC_SRST_BIT     = 1;
    localparam int          CC_MODULE_ENABLE_BIT    = 0;
    // status_and_flags fields, then carrier wave fields
    localparam int          SF_RUNNING_BIT  = 10;
    localparam int          SF_CYC_BSY_BIT  = 9;
    localparam int          SF_ACT_BSY_BIT  = 8;
    localparam int          SF_CYC_FLAG_BIT = 1;
    localparam int          SF_ACT_FLAG_BIT = 0;
    localparam int          CW_HIGH_LSB     = 8;
    localparam int          CW_PER_LSB      = 0;
    // clock sources
    localparam logic [1:0]  SRC_INT_OSC     = 2'h0;
    localparam logic [1:0]  SRC_LOW_OSC     = 2'h1;
    localparam logic [1:0]  SRC_HIGH_OSC    = 2'h2;
    localparam logic [1:0]  SRC_EXT_CLK     = 2'h3;
    localparam logic [3:0]  DIV_LOW_MAXOK   = 4'h8;
    localparam logic [3:0]  DIV_LOW_BYPASS  = 4'hF;
    localparam logic [15:0] ZERO16          = 16'h0000;
    localparam logic [7:0]  ZERO8           = 8'h00;
    localparam logic [14:0] PRE_ZERO        = 15'h0000;
    localparam logic [14:0] PRE_ONE         = 15'h0001;
endpackage

/* src/ircdm_top.sv */
// ircdm_top: infrared carrier/data modulator with its register port.
// assumes source oscillator ticks arrive as one-cycle enables synchronous
// to clock; registers are 16 bits at word indices.
`timescale 1ns/10ps

module ircdm_top
    import ircdm_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic      [DATA_W-1:0] rdata,
    input  wire logic              internal_oscillator,
    input  wire logic              low_speed_oscillator,
    input  wire logic              high_speed_oscillator,
    input  wire logic              external_clock_input,
    input  wire logic              debug_mode,
    output logic                   remote_output_pin,
    output logic                   irq
);

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic              debug_clock_keep;
        logic [3:0]        clock_divide_sel;
        logic [1:0]        clock_source_sel;
        logic              counter_reset;
        logic              counter_run;
        logic              output_invert;
        logic              compare_buffer_enable;
        logic              oneshot_select;
        logic              soft_reset;
        logic              module_enable;
        logic [14:0]       prescale;
        logic [15:0]       data_counter;
        logic [7:0]        carrier_counter;
        logic [15:0]       active_length;
        logic [15:0]       cycle_length;
        logic [15:0]       active_buf;
        logic [15:0]       cycle_buf;
        logic              active_len_busy;
        logic              cycle_len_busy;
        logic              cycle_match_flag;
        logic              active_match_flag;
        logic              cycle_match_enable;
        logic              active_match_enable;
        logic [7:0]        carrier_high_period;
        logic [7:0]        carrier_period;
        logic              carrier_enable;
        logic              data_level;
        logic              carrier_level;
        logic              pin;
    } ircdm_state_t;

    ircdm_state_t s_reg;
    ircdm_state_t s_next;

    // -----------------------------------------------------------------
    // operating clock enable
    // -----------------------------------------------------------------
    logic        src_tick;
    logic        div_ok;
    logic [14:0] div_mask;
    logic        op_tick;
    logic        wr_clk;
    logic        wr_ctl;
    logic        wr_act;
    logic        wr_cyc;
    logic        wr_flag;
    logic [15:0] cmp_act;
    logic [15:0] cmp_cyc;
    logic        act_hit;
    logic        cyc_hit;
    logic        counting;

    always_comb begin
        unique case (s_reg.clock_source_sel)
            SRC_INT_OSC:  src_tick = internal_oscillator;
            SRC_LOW_OSC:  src_tick = low_speed_oscillator;
            SRC_HIGH_OSC: src_tick = high_speed_oscillator;
            SRC_EXT_CLK:  src_tick = external_clock_input;
        endcase
    end

    // low osc 0xF is bypass, 0x9-0xE give no clock; external is never divided
    always_comb begin
        div_mask = PRE_ZERO;
        div_ok   = 1'b1;
        if (s_reg.clock_source_sel == SRC_LOW_OSC) begin
            if (s_reg.clock_divide_sel == DIV_LOW_BYPASS) begin
                div_mask = PRE_ZERO;
            end else if (s_reg.clock_divide_sel > DIV_LOW_MAXOK) begin
                div_ok = 1'b0;
            end else begin
                div_mask = (PRE_ONE << s_reg.clock_divide_sel) - PRE_ONE;
            end
        end else if (s_reg.clock_source_sel != SRC_EXT_CLK) begin
            div_mask = (PRE_ONE << s_reg.clock_divide_sel) - PRE_ONE;
        end
    end

    // one tick every 2^n source ticks: prescaler low bits all ones
    assign op_tick = s_reg.module_enable && src_tick && div_ok
                     && ((s_reg.prescale & div_mask) == div_mask)
                     && (!debug_mode || s_reg.debug_clock_keep);

    // -----------------------------------------------------------------
    // compare path
    // -----------------------------------------------------------------
    assign cmp_act  = s_reg.compare_buffer_enable ? s_reg.active_buf
                                                  : s_reg.active_length;
    assign cmp_cyc  = s_reg.compare_buffer_enable ? s_reg.cycle_buf
                                                  : s_reg.cycle_length;
    assign counting = s_reg.counter_run && !s_reg.soft_reset;
    assign act_hit  = op_tick && counting
                      && s_reg.data_counter == cmp_act;
    assign cyc_hit  = op_tick && counting
                      && s_reg.data_counter == cmp_cyc;

    assign wr_clk  = wr_en && addr == ADDR_CLK_SEL;
    assign wr_ctl  = wr_en && addr == ADDR_CNT_CTL;
    assign wr_act  = wr_en && addr == ADDR_ACT_LEN && s_reg.module_enable
                     && !(s_reg.compare_buffer_enable
                          && s_reg.active_len_busy);
    assign wr_cyc  = wr_en && addr == ADDR_CYC_LEN && s_reg.module_enable
                     && !(s_reg.compare_buffer_enable
                          && s_reg.cycle_len_busy);
    assign wr_flag = wr_en && addr == ADDR_STAT_FLAG;

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        if (src_tick && s_reg.module_enable) begin
            s_next.prescale = s_reg.prescale + PRE_ONE;
        end
        // soft reset and counter reset each take one cycle to complete
        s_next.soft_reset    = 1'b0;
        s_next.counter_reset = 1'b0;

        if (wr_clk && !s_reg.module_enable) begin
            s_next.debug_clock_keep = wdata[CS_DEBUG_BIT];
            s_next.clock_divide_sel = wdata[CS_DIV_LSB +: 4];
            s_next.clock_source_sel = wdata[CS_SRC_LSB +: 2];
        end

        // counting and compares
        if (op_tick && counting) begin
            s_next.carrier_counter = s_reg.carrier_counter + 8'h01;
            if (s_reg.carrier_counter == s_reg.carrier_high_period) begin
                s_next.carrier_level = 1'b0;
            end
            if (s_reg.carrier_counter == s_reg.carrier_period) begin
                s_next.carrier_counter = ZERO8;
                s_next.carrier_level   = 1'b1;
            end
            s_next.data_counter = s_reg.data_counter + 16'h0001;
            if (act_hit) begin
                s_next.data_level        = 1'b0;
                s_next.active_match_flag = 1'b1;
            end
            if (cyc_hit) begin
                s_next.data_counter     = ZERO16;
                s_next.data_level       = 1'b1;
                s_next.cycle_match_flag = 1'b1;
                if (s_reg.compare_buffer_enable) begin
                    s_next.active_buf      = s_reg.active_length;
                    s_next.cycle_buf       = s_reg.cycle_length;
                    s_next.active_len_busy = 1'b0;
                    s_next.cycle_len_busy  = 1'b0;
                end
                if (s_reg.oneshot_select) begin
                    s_next.counter_run = 1'b0;
                    s_next.data_level  = 1'b0;
                end
            end
        end

        // flag clears: a same-cycle compare event wins over the clear
        if (wr_flag) begin
            if (wdata[SF_ACT_FLAG_BIT] && !act_hit) begin
                s_next.active_match_flag = 1'b0;
            end
            if (wdata[SF_CYC_FLAG_BIT] && !cyc_hit) begin
                s_next.cycle_match_flag = 1'b0;
            end
        end

        if (wr_act) begin
            s_next.active_length = wdata;
            if (s_reg.compare_buffer_enable) begin
                s_next.active_len_busy = 1'b1;
            end
        end
        if (wr_cyc) begin
            s_next.cycle_length = wdata;
            if (s_reg.compare_buffer_enable) begin
                s_next.cycle_len_busy = 1'b1;
            end
        end

        if (wr_ctl) begin
            s_next.output_invert         = wdata[CC_INV_BIT];
            s_next.compare_buffer_enable = wdata[CC_BUF_BIT];
            s_next.oneshot_select        = wdata[CC_ONESHOT_BIT];
            s_next.module_enable         = wdata[CC_MODULE_ENABLE_BIT];
            if (s_reg.module_enable) begin
                s_next.counter_run = wdata[CC_RUN_BIT];
                if (wdata[CC_PRESET_BIT]) begin
                    s_next.counter_reset   = 1'b1;
                    s_next.data_counter    = ZERO16;
                    s_next.carrier_counter = ZERO8;
                    s_next.data_level      = 1'b1;
                    s_next.carrier_level   = 1'b1;
                end
            end
            if (wdata[CC_SRST_BIT]) begin
                s_next.soft_reset        = 1'b1;
                s_next.counter_reset     = 1'b0;
                s_next.counter_run       = 1'b0;
                s_next.data_counter      = ZERO16;
                s_next.carrier_counter   = ZERO8;
                s_next.data_level        = 1'b1;
                s_next.carrier_level     = 1'b1;
                s_next.active_match_flag = 1'b0;
                s_next.cycle_match_flag  = 1'b0;
            end
        end

        if (wr_en && addr == ADDR_INT_EN) begin
            s_next.cycle_match_enable  = wdata[SF_CYC_FLAG_BIT];
            s_next.active_match_enable = wdata[SF_ACT_FLAG_BIT];
        end
        if (wr_en && addr == ADDR_CARR_WAVE) begin
            s_next.carrier_high_period = wdata[CW_HIGH_LSB +: 8];
            s_next.carrier_period      = wdata[CW_PER_LSB +: 8];
        end
        if (wr_en && addr == ADDR_CARR_CTL) begin
            s_next.carrier_enable = wdata[0];
        end

        // output: data, ANDed with carrier when carrier_enable, held low unless counting, then optional inversion
        s_next.pin = (s_reg.carrier_enable
                      ? (s_reg.carrier_level && s_reg.data_level)
                      : s_reg.data_level) && counting;
        s_next.pin = s_next.pin ^ s_reg.output_invert;

        // register read, data stands the cycle after the strobe
        s_next.rdata = ZERO16;
        if (rd_en) begin
            unique case (addr)
                ADDR_CLK_SEL: begin
                    s_next.rdata[CS_DEBUG_BIT]    = s_reg.debug_clock_keep;
                    s_next.rdata[CS_DIV_LSB +: 4] = s_reg.clock_divide_sel;
                    s_next.rdata[CS_SRC_LSB +: 2] = s_reg.clock_source_sel;
                end
                ADDR_CNT_CTL: begin
                    s_next.rdata[CC_PRESET_BIT]  = s_reg.counter_reset;
                    s_next.rdata[CC_RUN_BIT]     = s_reg.counter_run;
                    s_next.rdata[CC_INV_BIT]     = s_reg.output_invert;
                    s_next.rdata[CC_BUF_BIT]     = s_reg.compare_buffer_enable;
                    s_next.rdata[CC_ONESHOT_BIT] = s_reg.oneshot_select;
                    s_next.rdata[CC_SRST_BIT]    = s_reg.soft_reset;
                    s_next.rdata[CC_MODULE_ENABLE_BIT]   = s_reg.module_enable;
                end
                ADDR_CNT_VAL: s_next.rdata = s_reg.data_counter;
                ADDR_ACT_LEN: s_next.rdata = s_reg.active_length;
                ADDR_CYC_LEN: s_next.rdata = s_reg.cycle_length;
                ADDR_STAT_FLAG: begin
                    s_next.rdata[SF_RUNNING_BIT]  = counting;
                    s_next.rdata[SF_CYC_BSY_BIT]  = s_reg.cycle_len_busy;
                    s_next.rdata[SF_ACT_BSY_BIT]  = s_reg.active_len_busy;
                    s_next.rdata[SF_CYC_FLAG_BIT] = s_reg.cycle_match_flag;
                    s_next.rdata[SF_ACT_FLAG_BIT] = s_reg.active_match_flag;
                end
                ADDR_INT_EN: begin
                    s_next.rdata[SF_CYC_FLAG_BIT] = s_reg.cycle_match_enable;
                    s_next.rdata[SF_ACT_FLAG_BIT] = s_reg.active_match_enable;
                end
                ADDR_CARR_WAVE: begin
                    s_next.rdata[CW_HIGH_LSB +: 8] = s_reg.carrier_high_period;
                    s_next.rdata[CW_PER_LSB +: 8]  = s_reg.carrier_period;
                end
                ADDR_CARR_CTL: s_next.rdata[0] = s_reg.carrier_enable;
                default:       s_next.rdata = ZERO16;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_reg               <= '0;
            s_reg.data_level    <= 1'b1;
            s_reg.carrier_level <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata             = s_reg.rdata;
    assign remote_output_pin = s_reg.pin;
    assign irq = (s_reg.cycle_match_flag && s_reg.cycle_match_enable)
              || (s_reg.active_match_flag && s_reg.active_match_enable);

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence seq_srst_write;
        wr_ctl && wdata[CC_SRST_BIT];
    endsequence
    sequence seq_cleared;
        !s_reg.counter_run && s_reg.data_counter == ZERO16
        && !s_reg.cycle_match_flag && !s_reg.active_match_flag;
    endsequence

    AST_SRST_CLEARS: assert property (
        seq_srst_write |=> seq_cleared ##1 !s_reg.soft_reset)
        else $error("soft reset did not clear state");
    AST_CLK_LOCK: assert property (
        s_reg.module_enable |=> $stable(s_reg.clock_divide_sel))
        else $error("clock select changed while enabled");
    AST_ONESHOT_STOP: assert property (
        cyc_hit && s_reg.oneshot_select && !wr_ctl |=> !s_reg.counter_run)
        else $error("one-shot did not stop");
    AST_CYC_WRAP: assert property (
        cyc_hit && !wr_ctl
        |=> s_reg.data_counter == ZERO16 && s_reg.cycle_match_flag)
        else $error("cycle match did not wrap counter");
    // a soft reset in the same cycle clears the flag on purpose
    AST_ACT_FLAG: assert property (
        act_hit && !(wr_ctl && wdata[CC_SRST_BIT])
        |=> s_reg.active_match_flag)
        else $error("active match flag not set");
    AST_IRQ: assert property (
        irq |-> (s_reg.cycle_match_flag || s_reg.active_match_flag))
        else $error("interrupt without flag");
    AST_LEN_IGNORE: assert property (
        wr_en && addr == ADDR_CYC_LEN && !s_reg.module_enable
        |=> $stable(s_reg.cycle_length))
        else $error("length write taken while disabled");
    AST_PRESET: assert property (
        wr_ctl && wdata[CC_PRESET_BIT] && s_reg.module_enable
        && !wdata[CC_SRST_BIT]
        |=> s_reg.counter_reset && s_reg.data_counter == ZERO16
        ##1 !s_reg.counter_reset)
        else $error("counter reset failed");
    AST_HOLD: assert property (
        !s_reg.module_enable && !wr_ctl |=> $stable(s_reg.data_counter))
        else $error("counter moved while disabled");
    AST_BUF_LOAD: assert property (
        cyc_hit && s_reg.compare_buffer_enable && !wr_act
        |=> !s_reg.active_len_busy
            && s_reg.cycle_buf == $past(s_reg.cycle_length))
        else $error("compare buffers not loaded at cycle end");

endmodule

/* tb/ircdm_emitter.sv */
// ircdm_emitter: infrared emitter seen from the remote output pin.
// assumes the pin is registered on clock; counts cycles with light on.
`timescale 1ns/10ps
module ircdm_emitter (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        drive,
    output logic      [15:0] lit_count
);
    // emitter lights while the pin is high; no pull, no memory
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) lit_count <= 16'h0000;
        else if (drive) lit_count <= lit_count + 16'h0001;
    end
endmodule

/* tb/testbench.sv */
// testbench: register-port scenarios for the modulator, emitter on pin.
// assumes internal oscillator ticks every cycle, divider 1/1 until the
// clock scenario sets 1/2.
`timescale 1ns/10ps
module testbench;
    import ircdm_pkg::*;
    logic              clock = 1'b0;
    logic              nrst = 1'b0;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [DATA_W-1:0] wdata = 16'h0000;
    logic              wr_en = 1'b0;
    logic              rd_en = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic              debug_mode = 1'b0;
    logic              remote_output_pin;
    logic              irq;
    logic [15:0]       lit_count;
    logic [15:0]       q;
    logic [15:0]       q2;
    int                fail_count = 0;
    int                cmp_count = 0;
    always #25 clock = ~clock;
    ircdm_top ircdm_top_inst (.clock(clock), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .internal_oscillator(1'b1), .low_speed_oscillator(1'b0),
        .high_speed_oscillator(1'b0), .external_clock_input(1'b0),
        .debug_mode(debug_mode), .remote_output_pin(remote_output_pin),
        .irq(irq));
    ircdm_emitter ircdm_emitter_inst (.clock(clock), .nrst(nrst),
        .drive(remote_output_pin), .lit_count(lit_count));
    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a; wdata <= d; wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        addr <= a; rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        @(negedge clock);
        d = rdata;
    endtask
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // light-on cycles over a whole number of output periods
    task automatic lit(input int n, output logic [15:0] h);
        logic [15:0] s;
        @(negedge clock);
        s = lit_count;
        repeat (n) @(negedge clock);
        h = lit_count - s;
    endtask
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_gates;
        rd(ADDR_CNT_VAL, q); chk("count", 16'h0000, q);
        rd(4'hF, q); chk("unmapped", 16'h0000, q);
        wr(ADDR_ACT_LEN, 16'h0001);
        rd(ADDR_ACT_LEN, q); chk("act_off", 16'h0000, q);
        wr(ADDR_CNT_CTL, 16'h0001);
        wr(ADDR_CLK_SEL, 16'h0011);
        rd(ADDR_CLK_SEL, q); chk("clk_sel", 16'h0000, q);
        wr(ADDR_ACT_LEN, 16'h0001);
        wr(ADDR_CYC_LEN, 16'h0005);
        rd(ADDR_CYC_LEN, q); chk("cyc_len", 16'h0005, q);
        $display("test gates done");
    endtask
    task automatic s_data;
        wr(ADDR_CNT_CTL, 16'h0301);
        rd(ADDR_STAT_FLAG, q);
        chk("running", 16'h0400, q & 16'h0400);
        lit(60, q); chk("data_lit", 16'h0014, q);
        wr(ADDR_INT_EN, 16'h0003);
        @(negedge clock);
        chk("irq_on", 16'h0001, {15'h0000, irq});
        wr(ADDR_CNT_CTL, 16'h0001);
        rd(ADDR_CNT_CTL, q); chk("run_off", 16'h0001, q);
        wr(ADDR_STAT_FLAG, 16'h0003);
        rd(ADDR_STAT_FLAG, q); chk("flags_clr", 16'h0000, q);
        chk("irq_off", 16'h0000, {15'h0000, irq});
        $display("test data done");
    endtask
    task automatic s_carrier;
        wr(ADDR_CARR_WAVE, 16'h0001);
        wr(ADDR_CARR_CTL, 16'h0001);
        wr(ADDR_CNT_CTL, 16'h0301);
        lit(60, q); chk("carr_lit", 16'h000A, q);
        // invert only with the carrier on; pin lags state by a cycle
        wr(ADDR_CNT_CTL, 16'h0111);
        repeat (2) @(posedge clock);
        lit(60, q); chk("inv_lit", 16'h0032, q);
        @(posedge clock);
        debug_mode <= 1'b1;
        rd(ADDR_CNT_VAL, q);
        rd(ADDR_CNT_VAL, q2); chk("debug_hold", 16'h0000, q2 - q);
        @(posedge clock);
        debug_mode <= 1'b0;
        $display("test carrier done");
    endtask
    task automatic s_oneshot;
        int i;
        wr(ADDR_CNT_CTL, 16'h0003);
        wr(ADDR_CARR_CTL, 16'h0000);
        wr(ADDR_CNT_CTL, 16'h0305);
        q = 16'h0100;
        for (i = 0; i < 20 && q[8] !== 1'b0; i++) rd(ADDR_CNT_CTL, q);
        chk("oneshot_run", 16'h0000, q & 16'h0100);
        lit(12, q); chk("oneshot_idle", 16'h0000, q);
        wr(ADDR_CNT_CTL, 16'h0003);
        rd(ADDR_STAT_FLAG, q); chk("srst_stat", 16'h0000, q);
        rd(ADDR_CNT_VAL, q); chk("srst_count", 16'h0000, q);
        $display("test oneshot done");
    endtask
    task automatic s_buffer;
        wr(ADDR_CNT_CTL, 16'h0009);
        wr(ADDR_ACT_LEN, 16'h0002);
        rd(ADDR_STAT_FLAG, q);
        chk("act_busy", 16'h0100, q & 16'h0100);
        wr(ADDR_ACT_LEN, 16'h0004);
        rd(ADDR_ACT_LEN, q); chk("busy_wr", 16'h0002, q);
        // empty buffers match at zero, so the first tick loads them
        wr(ADDR_CNT_CTL, 16'h0309);
        rd(ADDR_STAT_FLAG, q);
        chk("act_loaded", 16'h0000, q & 16'h0100);
        $display("test buffer done");
    endtask
    task automatic s_clock;
        wr(ADDR_CNT_CTL, 16'h0000);
        wr(ADDR_CLK_SEL, 16'h0110);
        rd(ADDR_CLK_SEL, q); chk("clk_open", 16'h0110, q);
        wr(ADDR_CNT_CTL, 16'h0003);
        wr(ADDR_CNT_CTL, 16'h0301);
        @(posedge clock);
        debug_mode <= 1'b1;
        // reads two cycles apart: one tick at 1/2, counter wraps past 5
        rd(ADDR_CNT_VAL, q);
        rd(ADDR_CNT_VAL, q2);
        chk("div_step", 16'h0001, (q2 + 16'h0006 - q) % 16'h0006);
        @(posedge clock);
        debug_mode <= 1'b0;
        $display("test clock done");
    endtask
    initial begin
        repeat (100000) @(posedge clock);
        fail_count++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        s_gates();
        s_data();
        s_carrier();
        s_oneshot();
        s_buffer();
        s_clock();
        close_out();
    end
endmodule
